// [common/status_bank_pkg.sv]
package status_bank_pkg;

  // ==========================================================
  // Register addresses (7-bit)
  localparam logic [6:0] ADDR_PIN_WAKE_EVENT   = 7'h47;
  localparam logic [6:0] ADDR_INPUT_LEVEL      = 7'h48;
  localparam logic [6:0] ADDR_SWITCH_OVERLOAD  = 7'h54;
  localparam logic [6:0] ADDR_SWITCH_OPEN_LOAD = 7'h55;

  // ==========================================================
  // Field positions
  localparam int POS_PIN_TWO_WAKE      = 5;
  localparam int POS_PIN_ONE_WAKE      = 4;
  localparam int POS_DEV_MODE_STRAP    = 7;
  localparam int POS_ALERT_PULLUP      = 6;
  localparam int POS_PIN_TWO_LEVEL     = 5;
  localparam int POS_PIN_ONE_LEVEL     = 4;
  localparam int POS_WAKE_THREE_LEVEL  = 2;
  localparam int POS_WAKE_TWO_LEVEL    = 1;
  localparam int POS_WAKE_ONE_LEVEL    = 0;

  // ==========================================================
  // Implemented-bit masks; all other bits read as zero
  localparam logic [7:0] MASK_PIN_WAKE_EVENT = 8'h30;
  localparam logic [7:0] MASK_INPUT_LEVEL    = 8'hF7;
  localparam logic [7:0] MASK_SWITCH_FAULT   = 8'h0F;

  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_PIN_WAKE_FLAGS = 2'h0;
  localparam logic [3:0] RST_SWITCH_FLAGS   = 4'h0;
  localparam logic [1:0] RST_PIN_LEVELS     = 2'h0;
  localparam logic [2:0] RST_WAKE_LEVELS    = 3'h0;
  localparam logic [7:0] READ_IDLE          = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PIN_CFG_OFF,
    PIN_CFG_WAKE,
    PIN_CFG_LOW_SIDE,
    PIN_CFG_HIGH_SIDE
  } pin_cfg_t;

  // Fault event pulses, index 0 is switch one
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] open_load;
  } switch_events_t;

  // Raw pin levels before synchronisation
  typedef struct packed {
    logic       mode_strap;
    logic       alert_pullup;
    logic [1:0] pin_level;
    logic [2:0] wake_level;
  } pin_levels_t;

  localparam int PIN_LEVELS_W = 7;

endpackage : status_bank_pkg

// [verilog/level_sync.sv]
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for asynchronous levels
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,   // System clock
  input  wire logic             rst_in,   // Async reset, active high
  input  wire logic [WIDTH-1:0] async_in, // Asynchronous levels
  output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : level_sync

// [verilog/wake_level_switch_status_regs.sv]
`timescale 1ns/10ps
// Overview of operation
// R1: Four 8-bit status registers at 0x47, 0x48, 0x54, 0x55, each selectable.
// R2: Reserved bits always read zero.
// R3: Bit 5 flags wake by pin two, bit 4 wake by pin one.
// R4: Power-on or soft reset clears wake-event and both fault registers.
// R5: Restart keeps both pin wake flags, all else zero.
// R6: Restart keeps fault bits 3:0 of both fault registers, upper nibble zero.
// R7: Level bit 7 shows mode strap: zero user, one development.
// R8: Level bit 6 shows one when alert pull-up is detected.
// R9: Level bits 5 and 4 show pin two and pin one levels.
// R10: Level bits 2 to 0 show wake inputs three to one.
// R11: After power-on or soft reset, level bits 5 and 4 read zero.
// R12: Pin levels refresh only in normal/stop mode and wake/switch config.
// R13: Cyclic wake inputs hold last sample, update after each sampling.
// R14: Pin levels never use the cyclic sampled update.
// R15: Selected pins show their level even as low- or high-side switch.
// R16: Overload bits 3 to 0 latch over-current/temperature on switches 4 to 1.
// R17: Open-load bits 3 to 0 latch open load on switches 4 to 1.
// R18: Latched flags stay set until the host clears them.
// R19: Wake from fail-safe also sets the responsible source's wake flag.
// R20: Level register is read-only; writes change nothing.
// R21: Set beats clear; a repeated event leaves the flag set.
module wake_level_switch_status_regs
  import status_bank_pkg::*;
(
  input  wire logic           clk_in,            // System clock, 40 MHz
  input  wire logic           rst_in,            // Power-on reset, async
  input  wire logic           soft_reset_in,     // Soft reset pulse
  input  wire logic           restart_in,        // Restart pulse
  // Host register port
  input  wire logic [6:0]     host_addr_in,      // Register address
  input  wire logic           host_rd_in,        // Read strobe
  input  wire logic           host_clr_in,       // Clear strobe
  input  wire logic [7:0]     host_clr_mask_in,  // Ones clear flags
  output logic      [7:0]     host_rd_data_out,  // Read data
  output logic                host_rd_valid_out, // Read data valid
  output logic                host_addr_err_out, // Unmapped access
  // Event sources, same clock
  input  wire logic [1:0]     pin_wake_in,       // Pin wake pulses
  input  wire logic [1:0]     failsafe_wake_in,  // Fail-safe wake by pin
  input  switch_events_t      switch_evt_in,     // Switch fault pulses
  // Configuration, same clock
  input  wire logic           normal_or_stop_in, // Normal or stop mode
  input  wire logic [1:0]     pin_gp_sel_in,     // Pin used as GP pin
  input  pin_cfg_t            pin_cfg_in [2],    // Pin function per pin
  input  wire logic [2:0]     wake_cyclic_in,    // Wake input cyclic mode
  input  wire logic [2:0]     wake_sample_in,    // Cyclic sample pulses
  // Asynchronous pin levels
  input  pin_levels_t         pin_levels_in,     // Raw pin levels
  // Register mirrors
  output logic      [1:0]     pin_wake_flags_out, // Pin wake flags
  output logic      [3:0]     overload_out,       // Overload flags
  output logic      [3:0]     open_load_out       // Open-load flags
);

  // ==========================================================
  // Address decode helpers
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_WAKE_EVENT,
    SEL_LEVEL,
    SEL_OVERLOAD,
    SEL_OPEN_LOAD
  } reg_sel_t;

  // Maps an address to a register
  function automatic reg_sel_t decode_addr(input logic [6:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      ADDR_PIN_WAKE_EVENT:   sel = SEL_WAKE_EVENT;
      ADDR_INPUT_LEVEL:      sel = SEL_LEVEL;
      ADDR_SWITCH_OVERLOAD:  sel = SEL_OVERLOAD;
      ADDR_SWITCH_OPEN_LOAD: sel = SEL_OPEN_LOAD;
      default:               sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // Sticky flag update, set wins over clear
  function automatic logic [3:0] sticky(input logic [3:0] cur,
                                        input logic [3:0] set,
                                        input logic [3:0] clr);
    return (cur & ~clr) | set;
  endfunction : sticky

  // ==========================================================
  // Synchronised pin levels
  pin_levels_t lvl_sync;

  level_sync #(
    .WIDTH (PIN_LEVELS_W)
  ) u_level_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (pin_levels_in),
    .sync_out (lvl_sync)
  );

  // ==========================================================
  // State
  logic [1:0] pin_wake_q,   pin_wake_d;
  logic [3:0] overload_q,   overload_d;
  logic [3:0] open_load_q,  open_load_d;
  logic       strap_q,      strap_d;
  logic       pullup_q,     pullup_d;
  logic [1:0] pin_level_q,  pin_level_d;
  logic [2:0] wake_level_q, wake_level_d;
  logic [7:0] rd_data_q,    rd_data_d;
  logic       rd_valid_q,   rd_valid_d;
  logic       addr_err_q,   addr_err_d;

  reg_sel_t   host_sel;
  logic [3:0] clr_wake;
  logic [3:0] clr_overload;
  logic [3:0] clr_open_load;
  logic [3:0] set_wake;
  logic [1:0] pin_refresh;
  logic [7:0] wake_event_view;
  logic [7:0] level_view;
  logic [7:0] overload_view;
  logic [7:0] open_load_view;

  // Select decoded once, used by read and clear
  assign host_sel = decode_addr(host_addr_in); // R1

  // ==========================================================
  // Clear requests per register
  always_comb begin
    clr_wake      = 4'h0;
    clr_overload  = 4'h0;
    clr_open_load = 4'h0;
    if (host_clr_in) begin
      case (host_sel)
        SEL_WAKE_EVENT: clr_wake      = {2'h0,
          host_clr_mask_in[POS_PIN_TWO_WAKE],
          host_clr_mask_in[POS_PIN_ONE_WAKE]}; // R18
        SEL_OVERLOAD:   clr_overload  = host_clr_mask_in[3:0]; // R18
        SEL_OPEN_LOAD:  clr_open_load = host_clr_mask_in[3:0]; // R18
        SEL_LEVEL:      clr_wake      = 4'h0; // R20
        default:        clr_wake      = 4'h0;
      endcase
    end
  end

  // Wake sources, normal or from fail-safe
  assign set_wake = {2'h0, pin_wake_in | failsafe_wake_in}; // R3 R19

  // ==========================================================
  // Latched flag next values
  always_comb begin
    pin_wake_d  = pin_wake_q;
    overload_d  = overload_q;
    open_load_d = open_load_q;
    if (soft_reset_in) begin
      pin_wake_d  = RST_PIN_WAKE_FLAGS; // R4
      overload_d  = RST_SWITCH_FLAGS;   // R4
      open_load_d = RST_SWITCH_FLAGS;   // R4
    end else begin
      // Restart keeps flags; only reserved bits are zeroed  R5 R6
      // Wake flags padded to the sticky width, upper bits dropped
      pin_wake_d  = 2'(sticky({2'h0, pin_wake_q}, set_wake,
                              clr_wake)); // R3 R18 R21
      overload_d  = sticky(overload_q, switch_evt_in.overload,
                           clr_overload); // R16 R21
      open_load_d = sticky(open_load_q, switch_evt_in.open_load,
                           clr_open_load); // R17 R21
    end
  end

  // Latched flag registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_wake_q  <= RST_PIN_WAKE_FLAGS; // R4
      overload_q  <= RST_SWITCH_FLAGS;   // R4
      open_load_q <= RST_SWITCH_FLAGS;   // R4
    end else begin
      pin_wake_q  <= pin_wake_d;
      overload_q  <= overload_d;
      open_load_q <= open_load_d;
    end
  end

  // ==========================================================
  // Pin level refresh qualifier
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_refresh[i] = pin_gp_sel_in[i] && normal_or_stop_in &&
                       (pin_cfg_in[i] != PIN_CFG_OFF); // R12 R15
    end
  end

  // ==========================================================
  // Level register next values
  always_comb begin
    strap_d      = lvl_sync.mode_strap;   // R7
    pullup_d     = lvl_sync.alert_pullup; // R8
    pin_level_d  = pin_level_q;
    wake_level_d = wake_level_q;
    // Pins follow live level only, never a sample pulse  R14
    for (int i = 0; i < 2; i++) begin
      if (pin_refresh[i]) begin
        pin_level_d[i] = lvl_sync.pin_level[i]; // R9 R12
      end
    end
    // Wake inputs: live, or held between samples when cyclic
    for (int i = 0; i < 3; i++) begin
      if (!wake_cyclic_in[i] || wake_sample_in[i]) begin
        wake_level_d[i] = lvl_sync.wake_level[i]; // R10 R13
      end
    end
    if (soft_reset_in) begin
      pin_level_d = RST_PIN_LEVELS; // R11
    end
  end

  // Level register flip-flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_q      <= 1'b0;
      pullup_q     <= 1'b0;
      pin_level_q  <= RST_PIN_LEVELS;  // R11
      wake_level_q <= RST_WAKE_LEVELS;
    end else begin
      strap_q      <= strap_d;
      pullup_q     <= pullup_d;
      pin_level_q  <= pin_level_d;
      wake_level_q <= wake_level_d;
    end
  end

  // ==========================================================
  // Register views with reserved bits forced low
  always_comb begin
    wake_event_view = 8'h00;
    wake_event_view[POS_PIN_TWO_WAKE] = pin_wake_q[1]; // R3
    wake_event_view[POS_PIN_ONE_WAKE] = pin_wake_q[0]; // R3
    wake_event_view = wake_event_view & MASK_PIN_WAKE_EVENT; // R2

    level_view = 8'h00;
    level_view[POS_DEV_MODE_STRAP]   = strap_q;         // R7
    level_view[POS_ALERT_PULLUP]     = pullup_q;        // R8
    level_view[POS_PIN_TWO_LEVEL]    = pin_level_q[1];  // R9
    level_view[POS_PIN_ONE_LEVEL]    = pin_level_q[0];  // R9
    level_view[POS_WAKE_THREE_LEVEL] = wake_level_q[2]; // R10
    level_view[POS_WAKE_TWO_LEVEL]   = wake_level_q[1]; // R10
    level_view[POS_WAKE_ONE_LEVEL]   = wake_level_q[0]; // R10
    level_view = level_view & MASK_INPUT_LEVEL; // R2

    overload_view  = {4'h0, overload_q}  & MASK_SWITCH_FAULT; // R2 R16
    open_load_view = {4'h0, open_load_q} & MASK_SWITCH_FAULT; // R2 R17
  end

  // ==========================================================
  // Host read path, data registered one cycle after strobe
  always_comb begin
    rd_data_d  = READ_IDLE;
    rd_valid_d = 1'b0;
    addr_err_d = 1'b0;
    if (host_rd_in || host_clr_in) begin
      addr_err_d = (host_sel == SEL_NONE);
    end
    if (host_rd_in) begin
      rd_valid_d = 1'b1;
      case (host_sel)
        SEL_WAKE_EVENT: rd_data_d = wake_event_view; // R1
        SEL_LEVEL:      rd_data_d = level_view;      // R1
        SEL_OVERLOAD:   rd_data_d = overload_view;   // R1
        SEL_OPEN_LOAD:  rd_data_d = open_load_view;  // R1
        default:        rd_data_d = READ_IDLE;
      endcase
    end
  end

  // Read answer registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_q  <= READ_IDLE;
      rd_valid_q <= 1'b0;
      addr_err_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      addr_err_q <= addr_err_d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign host_rd_data_out   = rd_data_q;
  assign host_rd_valid_out  = rd_valid_q;
  assign host_addr_err_out  = addr_err_q;
  assign pin_wake_flags_out = pin_wake_q;
  assign overload_out       = overload_q;
  assign open_load_out      = open_load_q;

  // Restart needs no action: kept bits hold, others are constant zero
  logic unused_restart;
  assign unused_restart = restart_in; // R5 R6

endmodule : wake_level_switch_status_regs

// [dv/status_bank_monitor.sv]
`timescale 1ns/10ps
// ==========================================================
// Status bank checker
module status_bank_monitor
  import status_bank_pkg::*;
(
  input wire logic       clk_in,             // Clock
  input wire logic       rst_in,             // Reset
  input wire logic       soft_reset_in,      // Soft reset
  input wire logic [6:0] host_addr_in,       // Address
  input wire logic       host_rd_in,         // Read
  input wire logic       host_clr_in,        // Clear
  input wire logic [7:0] host_rd_data_out,   // Read data
  input wire logic       host_rd_valid_out,  // Valid
  input wire logic       host_addr_err_out,  // Unmapped
  input wire logic [1:0] pin_wake_in,        // Wake pulses
  input wire logic [1:0] failsafe_wake_in,   // Fail-safe wake
  input switch_events_t  switch_evt_in,      // Fault pulses
  input wire logic [1:0] pin_wake_flags_out, // Wake flags
  input wire logic [3:0] overload_out,       // Overload
  input wire logic [3:0] open_load_out       // Open load
);
  logic       mapped;
  logic [9:0] flags;
  logic [1:0] wake_req;
  // Helper terms
  assign mapped = host_addr_in inside {ADDR_PIN_WAKE_EVENT, ADDR_INPUT_LEVEL,
    ADDR_SWITCH_OVERLOAD, ADDR_SWITCH_OPEN_LOAD};
  assign flags = {pin_wake_flags_out, overload_out, open_load_out};
  assign wake_req = pin_wake_in | failsafe_wake_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // Sequences
  sequence s_rd(logic [6:0] a);
    host_rd_in && host_addr_in == a;
  endsequence
  sequence s_quiet;
    !soft_reset_in && !host_clr_in;
  endsequence

  // ==========================================================
  // Properties
  property p_answer;
    host_rd_in |=> host_rd_valid_out && host_addr_err_out == !$past(mapped);
  endproperty
  a_answer: assert property (p_answer) else $error("bad answer");
  property p_clr_err;
    host_clr_in && !host_rd_in |=>
      !host_rd_valid_out && host_addr_err_out == !$past(mapped);
  endproperty
  a_clr_err: assert property (p_clr_err) else $error("clear answer");
  property p_wake_rd;
    s_rd(ADDR_PIN_WAKE_EVENT) |=>
      host_rd_data_out == {2'h0, $past(pin_wake_flags_out), 4'h0};
  endproperty
  a_wake_rd: assert property (p_wake_rd) else $error("wake read");
  property p_ovl_rd;
    s_rd(ADDR_SWITCH_OVERLOAD) |=>
      host_rd_data_out == {4'h0, $past(overload_out)};
  endproperty
  a_ovl_rd: assert property (p_ovl_rd) else $error("overload read");
  property p_ol_rd;
    s_rd(ADDR_SWITCH_OPEN_LOAD) |=>
      host_rd_data_out == {4'h0, $past(open_load_out)};
  endproperty
  a_ol_rd: assert property (p_ol_rd) else $error("open load read");
  property p_lvl_rd;
    s_rd(ADDR_INPUT_LEVEL) |=> host_rd_data_out[3] == 1'b0;
  endproperty
  a_lvl_rd: assert property (p_lvl_rd) else $error("level bit 3 set");
  property p_soft;
    soft_reset_in |=> flags == 10'h000;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept");
  property p_fault_set;
    !soft_reset_in |=> ({overload_out, open_load_out} & $past(switch_evt_in))
      == $past(switch_evt_in);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault lost");
  property p_wake_set;
    !soft_reset_in |=> (pin_wake_flags_out & $past(wake_req)) == $past(wake_req);
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake lost");
  property p_hold;
    s_quiet |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
endmodule : status_bank_monitor

bind wake_level_switch_status_regs status_bank_monitor u_status_bank_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
  .host_addr_in(host_addr_in), .host_rd_in(host_rd_in),
  .host_clr_in(host_clr_in), .host_rd_data_out(host_rd_data_out),
  .host_rd_valid_out(host_rd_valid_out),
  .host_addr_err_out(host_addr_err_out), .pin_wake_in(pin_wake_in),
  .failsafe_wake_in(failsafe_wake_in), .switch_evt_in(switch_evt_in),
  .pin_wake_flags_out(pin_wake_flags_out), .overload_out(overload_out),
  .open_load_out(open_load_out)
);

// [dv/host_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Host controller issuing reads and clears
module host_model (
  input  wire logic       clk_in,   // Clock
  output logic            rd_out,   // Read strobe
  output logic            clr_out,  // Clear strobe
  output logic      [6:0] addr_out, // Address
  output logic      [7:0] mask_out  // Clear mask
);
  // Idle bus at time zero
  initial begin
    rd_out = 1'b0;
    clr_out = 1'b0;
    addr_out = 7'h7F;
    mask_out = 8'h00;
  end
  // One read, released bus shows inverted values
  task automatic rd(input logic [6:0] a);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
  endtask : rd
  // Flags go down by this host clear or by soft reset
  task automatic clr(input logic [6:0] a, input logic [7:0] m);
    @(negedge clk_in);
    clr_out = 1'b1;
    addr_out = a;
    mask_out = m;
    @(negedge clk_in);
    clr_out = 1'b0;
    addr_out = ~a;
    mask_out = ~m;
  endtask : clr
endmodule : host_model

// [dv/tb.sv]
`timescale 1ns/10ps
// ==========================================================
// Status bank testbench
module tb
  import status_bank_pkg::*;
;
  logic           clk_in = 1'b0;
  logic           rst_in, soft_reset_in, restart_in, normal_or_stop_in;
  logic           host_rd_in, host_clr_in, host_rd_valid_out;
  logic           host_addr_err_out;
  logic [6:0]     host_addr_in;
  logic [7:0]     host_clr_mask_in, host_rd_data_out;
  logic [1:0]     pin_wake_in, failsafe_wake_in, pin_gp_sel_in;
  logic [2:0]     wake_cyclic_in, wake_sample_in, wake_m;
  logic [1:0]     pin_wake_flags_out, wk_m, pin_m;
  logic [3:0]     overload_out, open_load_out, ov_m, ol_m;
  switch_events_t switch_evt_in;
  pin_cfg_t       pin_cfg_in [2];
  pin_levels_t    pin_levels_in;
  logic [8:0]     exp_q [$];
  logic [31:0]    r = 32'h159B4A90;
  logic [6:0]     addrs [7] = '{7'h47, 7'h48, 7'h54, 7'h55, 7'h49, 7'h00, 7'h7F};
  int             errors, comparisons, cycles;

  always #12.5 clk_in = ~clk_in;

  wake_level_switch_status_regs u_wake_level_switch_status_regs (
    .clk_in(clk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
    .restart_in(restart_in), .host_addr_in(host_addr_in),
    .host_rd_in(host_rd_in), .host_clr_in(host_clr_in),
    .host_clr_mask_in(host_clr_mask_in), .host_rd_data_out(host_rd_data_out),
    .host_rd_valid_out(host_rd_valid_out),
    .host_addr_err_out(host_addr_err_out), .pin_wake_in(pin_wake_in),
    .failsafe_wake_in(failsafe_wake_in), .switch_evt_in(switch_evt_in),
    .normal_or_stop_in(normal_or_stop_in), .pin_gp_sel_in(pin_gp_sel_in),
    .pin_cfg_in(pin_cfg_in), .wake_cyclic_in(wake_cyclic_in),
    .wake_sample_in(wake_sample_in), .pin_levels_in(pin_levels_in),
    .pin_wake_flags_out(pin_wake_flags_out), .overload_out(overload_out),
    .open_load_out(open_load_out));
  host_model u_host_model (.clk_in(clk_in), .rd_out(host_rd_in),
    .clr_out(host_clr_in), .addr_out(host_addr_in),
    .mask_out(host_clr_mask_in));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Read with its expected answer noted first
  task automatic rd(input logic [6:0] a);
    case (a)
      ADDR_PIN_WAKE_EVENT:   exp_q.push_back({3'h0, wk_m, 4'h0});
      ADDR_INPUT_LEVEL:      exp_q.push_back({1'b0, pin_levels_in.mode_strap,
        pin_levels_in.alert_pullup, pin_m, 1'b0, wake_m});
      ADDR_SWITCH_OVERLOAD:  exp_q.push_back({5'h00, ov_m});
      ADDR_SWITCH_OPEN_LOAD: exp_q.push_back({5'h00, ol_m});
      default:               exp_q.push_back(9'h100);
    endcase
    u_host_model.rd(a);
  endtask : rd
  task automatic rd3;
    rd(ADDR_PIN_WAKE_EVENT);
    rd(ADDR_SWITCH_OVERLOAD);
    rd(ADDR_SWITCH_OPEN_LOAD);
  endtask : rd3
  // One-cycle event pulse, w is fail-safe then pin wake
  task automatic pulse(input logic [7:0] e, input logic [3:0] w);
    @(negedge clk_in);
    switch_evt_in = e;
    {failsafe_wake_in, pin_wake_in} = w;
    ov_m |= e[7:4];
    ol_m |= e[3:0];
    wk_m |= w[3:2] | w[1:0];
    @(negedge clk_in);
    switch_evt_in = '0;
    {failsafe_wake_in, pin_wake_in} = 4'h0;
  endtask : pulse
  // Clear with an event in the same cycle; set wins
  task automatic clr_with(input logic [6:0] a, input logic [7:0] m,
                          input logic [7:0] e);
    if (a == ADDR_SWITCH_OVERLOAD) ov_m &= ~m[3:0];
    if (a == ADDR_SWITCH_OPEN_LOAD) ol_m &= ~m[3:0];
    if (a == ADDR_PIN_WAKE_EVENT) wk_m &= ~m[5:4];
    fork
      u_host_model.clr(a, m);
      pulse(e, 4'h0);
    join
  endtask : clr_with
  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : settle

  // Scoreboard takes the oldest note on each answer
  always @(negedge clk_in) begin
    if (host_rd_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(9'h1FF, 9'h000);
      else check({host_addr_err_out, host_rd_data_out}, exp_q.pop_front());
    end
  end
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    {rst_in, soft_reset_in, restart_in, normal_or_stop_in} = 4'h8;
    {pin_wake_in, failsafe_wake_in, pin_gp_sel_in} = 6'h00;
    {wake_cyclic_in, wake_sample_in} = 6'h00;
    switch_evt_in = '0;
    pin_cfg_in[0] = PIN_CFG_OFF;
    pin_cfg_in[1] = PIN_CFG_OFF;
    pin_levels_in = pin_levels_t'(r[6:0]);
    {ov_m, ol_m, wk_m, pin_m} = 12'h000;
    wake_m = pin_levels_in.wake_level;
    settle(8);
    rst_in = 1'b0;
    settle(4);
    foreach (addrs[i]) rd(addrs[i]);
    u_host_model.clr(7'h49, 8'hFF);
    check({8'h00, host_addr_err_out}, 9'h001);
    repeat (12) begin
      r = lfsr(r);
      pulse(r[7:0], r[11:8]);
      r = lfsr(r);
      clr_with(addrs[r[1:0]], r[15:8], r[23:16]);
      rd3();
      rd(ADDR_INPUT_LEVEL);
      check({1'b0, overload_out, open_load_out}, {1'b0, ov_m, ol_m});
    end
    pulse(8'hFF, 4'h3);
    settle(1);
    restart_in = 1'b1;
    settle(1);
    restart_in = 1'b0;
    rd3();
    normal_or_stop_in = 1'b1;
    pin_gp_sel_in = 2'h3;
    for (int c = 1; c < 4; c++) begin
      pin_cfg_in[0] = pin_cfg_t'(c);
      pin_cfg_in[1] = pin_cfg_t'(c);
      pin_levels_in.pin_level = c[1:0];
      pin_levels_in.mode_strap = c[0];
      pin_levels_in.alert_pullup = c[1];
      settle(4);
      pin_m = c[1:0];
      rd(ADDR_INPUT_LEVEL);
    end
    pin_gp_sel_in = 2'h1;
    pin_levels_in.pin_level = 2'h0;
    settle(4);
    pin_m = 2'h2;
    rd(ADDR_INPUT_LEVEL);
    pin_gp_sel_in = 2'h3;
    pin_cfg_in[0] = PIN_CFG_OFF;
    pin_cfg_in[1] = PIN_CFG_OFF;
    pin_levels_in.pin_level = 2'h1;
    settle(4);
    rd(ADDR_INPUT_LEVEL);
    pin_cfg_in[0] = PIN_CFG_WAKE;
    pin_cfg_in[1] = PIN_CFG_WAKE;
    normal_or_stop_in = 1'b0;
    settle(4);
    rd(ADDR_INPUT_LEVEL);
    wake_cyclic_in = 3'h7;
    pin_levels_in.wake_level = ~wake_m;
    settle(4);
    rd(ADDR_INPUT_LEVEL);
    settle(1);
    wake_sample_in = 3'h7;
    settle(1);
    wake_sample_in = 3'h0;
    wake_m = pin_levels_in.wake_level;
    settle(2);
    rd(ADDR_INPUT_LEVEL);
    fork
      pulse(8'hFF, 4'hF);
      begin
        settle(1);
        soft_reset_in = 1'b1;
        settle(1);
        soft_reset_in = 1'b0;
      end
    join
    {ov_m, ol_m, wk_m, pin_m} = 12'h000;
    rd3();
    rd(ADDR_INPUT_LEVEL);
    settle(3);
    check(9'(exp_q.size()), 9'h000);
    report_and_stop();
  end
endmodule : tb
